//--- logic/mac_pkg.sv
// Constants shared by the MAC gap timer and receive alignment statistics
package mac_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry, counter and field widths
    // ------------------------------------------------------------------
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 8;
    localparam int          CNT_W        = 16;
    localparam int          GAP_W        = 7;
    localparam int          NIB_W        = 8;

    // ------------------------------------------------------------------
    // Register offsets; the alignment and gap groups have set, clear and invert aliases
    // ------------------------------------------------------------------
    localparam logic [7:0]  ALIGN_OFS    = 8'h00;
    localparam logic [7:0]  GAP_OFS      = 8'h10;
    localparam logic [7:0]  CTRL_OFS     = 8'h20;
    localparam logic [7:0]  IRQ_STAT_OFS = 8'h24;
    localparam logic [7:0]  IRQ_MASK_OFS = 8'h28;
    localparam logic [7:0]  CLR_OFS      = 8'h04;
    localparam logic [7:0]  SET_OFS      = 8'h08;
    localparam logic [7:0]  INV_OFS      = 8'h0c;

    // ------------------------------------------------------------------
    // Field positions and values after reset
    // ------------------------------------------------------------------
    localparam logic [6:0]  GAP_RESET    = 7'h12;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam int          CTRL_FD_BIT  = 0;
    localparam logic [0:0]  CTRL_RESET   = 1'h0;
    localparam int          EV_ALIGN_BIT = 0;
    localparam int          EV_GAP_BIT   = 1;
    localparam int          EV_W         = 2;
    localparam logic [1:0]  EV_RESET     = 2'h0;

    // ------------------------------------------------------------------
    // Gap adders in nibble times, and the alignment test modulus
    // ------------------------------------------------------------------
    localparam logic [7:0]  FD_GAP_ADD   = 8'h03;
    localparam logic [7:0]  HD_GAP_ADD   = 8'h06;
    localparam int          ALIGN_BITS   = 8;
    localparam int          LEN_LSB_W    = 3;

    // Legal byte-enable patterns: one word or one aligned half-word
    localparam logic [3:0]  BE_WORD      = 4'hf;
    localparam logic [3:0]  BE_LO_HALF   = 4'h3;
    localparam logic [3:0]  BE_HI_HALF   = 4'hc;

    // Write flavours of a register group
    typedef enum logic [3:0] {
        WR_DIRECT = 4'b0001,
        WR_CLR    = 4'b0010,
        WR_SET    = 4'b0100,
        WR_INV    = 4'b1000
    } wr_op_t;

endpackage

//--- logic/core_if.sv
// Internal bundle between the register front end, counter and gap timer
interface core_if;
    import mac_pkg::*;

    logic             cnt_inc;
    logic             cnt_rd_clear;
    logic             cnt_wr_en;
    logic [CNT_W-1:0] cnt_wr_val;
    logic [CNT_W-1:0] cnt_value;
    logic [GAP_W-1:0] gap_field;
    logic             full_duplex;
    logic             frame_end;
    logic             nibble_tick;
    logic             gap_open;

    modport ctr (input cnt_inc, cnt_rd_clear, cnt_wr_en, cnt_wr_val, output cnt_value);
    modport gap (input gap_field, full_duplex, frame_end, nibble_tick, output gap_open);
    modport top (output cnt_inc, cnt_rd_clear, cnt_wr_en, cnt_wr_val,
                 output gap_field, full_duplex, frame_end, nibble_tick,
                 input cnt_value, gap_open);
endinterface

//--- logic/align_err_counter.sv
// Receive alignment error counter with clear-on-read
module align_err_counter (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    core_if.ctr       bus
);
    import mac_pkg::*;

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] base;

    // ------------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------------
    // A frame counted in the same cycle as the clearing read survives as 1,
    // since the read returned the old total without it
    assign base       = bus.cnt_wr_en    ? bus.cnt_wr_val :
                        bus.cnt_rd_clear ? CNT_RESET      : count_reg;
    // Plain modulo add: all ones rolls to zero and nothing else is flagged
    assign count_next = base + {{(CNT_W-1){1'b0}}, bus.cnt_inc};

    // Count storage
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= CNT_RESET;
        end else if (ce_i) begin
            count_reg <= count_next;
        end
    end

    assign bus.cnt_value = count_reg;
endmodule

//--- logic/tx_gap_timer.sv
// Back-to-back interpacket gap timer for the transmitter
module tx_gap_timer (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    core_if.gap       bus
);
    import mac_pkg::*;

    logic [NIB_W-1:0] nib_reg;
    logic [NIB_W-1:0] nib_next;
    logic [NIB_W-1:0] target;
    logic             open_reg;
    logic             open_next;

    // ------------------------------------------------------------------
    // Gap target in nibble times
    // ------------------------------------------------------------------
    // Field is an offset: full duplex adds 3, half duplex adds 6
    assign target = {1'b0, bus.gap_field}
                  + (bus.full_duplex ? FD_GAP_ADD : HD_GAP_ADD);

    // Nibbles since end of packet; saturates so a long idle stays open
    assign nib_next  = bus.frame_end ? '0 :
                       (bus.nibble_tick && nib_reg != '1) ? nib_reg + 8'h01 : nib_reg;
    // Once open it stays open until the next end, so a field rewrite cannot reclose it
    assign open_next = !bus.frame_end && (open_reg || nib_next >= target);

    // Timer state; the line counts as long idle after reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            nib_reg  <= '1;
            open_reg <= 1'b1;
        end else if (ce_i) begin
            nib_reg  <= nib_next;
            open_reg <= open_next;
        end
    end

    assign bus.gap_open = open_reg;
endmodule

//--- logic/mac_ipg_stats.sv
// MAC slice: register front end, alignment statistics and transmit gap timing
//
// Added by the designer: the placing of the registers and the strobed register port.
import mac_pkg::*;

module mac_ipg_stats (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          ce_i,
    input  wire logic [mac_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [mac_pkg::DATA_W-1:0]    wdata_i,
    input  wire logic [3:0]                    be_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [mac_pkg::DATA_W-1:0]    rdata_o,
    output logic                               irq_o,
    input  wire logic                          rx_frame_done_i,
    input  wire logic                          rx_fcs_bad_i,
    input  wire logic [mac_pkg::LEN_LSB_W-1:0] rx_len_bits_i,
    input  wire logic                          tx_frame_end_i,
    input  wire logic                          nibble_tick_i,
    output logic                               tx_gap_open_o
);
    import mac_pkg::*;

    // ------------------------------------------------------------------
    // Write merge helper, shared by every register group except the interrupt status
    // ------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] merge_write(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] data,
        input logic [3:0]        be,
        input wr_op_t            op
    );
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] bits;
        mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        bits = data & mask;
        case (op)
            WR_CLR:  merge_write = old & ~bits;
            WR_SET:  merge_write = old | bits;
            WR_INV:  merge_write = old ^ bits;
            default: merge_write = (old & ~mask) | bits;
        endcase
    endfunction

    // Alias offset within a 16-byte group to a write flavour
    function automatic wr_op_t alias_op(input logic [ADDR_W-1:0] addr);
        logic [7:0] low;
        low = {4'h0, addr[3:0]};
        if (low == CLR_OFS) begin
            alias_op = WR_CLR;
        end else if (low == SET_OFS) begin
            alias_op = WR_SET;
        end else if (low == INV_OFS) begin
            alias_op = WR_INV;
        end else begin
            alias_op = WR_DIRECT;
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers and internal wires
    // ------------------------------------------------------------------
    logic [GAP_W-1:0]  gap_field_reg;
    logic [GAP_W-1:0]  gap_field_next;
    logic [0:0]        ctrl_reg;
    logic [0:0]        ctrl_next;
    logic [EV_W-1:0]   irq_stat_reg;
    logic [EV_W-1:0]   irq_stat_next;
    logic [EV_W-1:0]   irq_mask_reg;
    logic [EV_W-1:0]   irq_mask_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              irq_reg;
    logic              irq_next;
    logic              gap_open_d_reg;

    logic              sel_align;
    logic              sel_gap;
    logic              sel_ctrl;
    logic              sel_stat;
    logic              sel_mask;
    logic              be_legal;
    logic              wr_ok;
    logic              rd_ok;
    wr_op_t            op;
    logic [DATA_W-1:0] align_word;
    logic [DATA_W-1:0] gap_word;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] mask_word;
    logic [DATA_W-1:0] read_mux;
    logic [DATA_W-1:0] align_merged;
    logic [DATA_W-1:0] gap_merged;
    logic [DATA_W-1:0] ctrl_merged;
    logic [DATA_W-1:0] mask_merged;
    logic              align_event;
    logic              gap_event;
    logic [EV_W-1:0]   events;
    logic [EV_W-1:0]   stat_clear;

    core_if core ();

    // ------------------------------------------------------------------
    // Address decode; the alignment and gap groups span base plus three aliases, the others one word each
    // ------------------------------------------------------------------
    always_comb begin
        sel_align = 1'b0;
        sel_gap   = 1'b0;
        sel_ctrl  = 1'b0;
        sel_stat  = 1'b0;
        sel_mask  = 1'b0;
        if (addr_i[7:4] == ALIGN_OFS[7:4]) begin
            sel_align = 1'b1;
        end else if (addr_i[7:4] == GAP_OFS[7:4]) begin
            sel_gap = 1'b1;
        end else if (addr_i == CTRL_OFS) begin
            sel_ctrl = 1'b1;
        end else if (addr_i == IRQ_STAT_OFS) begin
            sel_stat = 1'b1;
        end else if (addr_i == IRQ_MASK_OFS) begin
            sel_mask = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Access width qualification
    // ------------------------------------------------------------------
    // Byte-wide accesses are dropped whole: no store, no clear, zero data.
    // Only word and aligned half-word patterns pass.
    assign be_legal = (be_i == BE_WORD) || (be_i == BE_LO_HALF)
                   || (be_i == BE_HI_HALF);
    assign wr_ok    = wr_i && be_legal;
    assign rd_ok    = rd_i && be_legal;
    assign op       = alias_op(addr_i);

    // ------------------------------------------------------------------
    // Register images as software sees them
    // ------------------------------------------------------------------
    // Upper half of the statistics word is not implemented
    assign align_word = {{(DATA_W-CNT_W){1'b0}}, core.cnt_value};
    assign gap_word   = {{(DATA_W-GAP_W){1'b0}}, gap_field_reg};
    assign ctrl_word  = {{(DATA_W-1){1'b0}}, ctrl_reg};
    assign stat_word  = {{(DATA_W-EV_W){1'b0}}, irq_stat_reg};
    assign mask_word  = {{(DATA_W-EV_W){1'b0}}, irq_mask_reg};

    // Read selection; unmapped offsets read as zero
    assign read_mux = !rd_ok    ? '0         :
                      sel_align ? align_word :
                      sel_gap   ? gap_word   :
                      sel_ctrl  ? ctrl_word  :
                      sel_stat  ? stat_word  :
                      sel_mask  ? mask_word  : '0;

    // ------------------------------------------------------------------
    // Write merging: alignment and gap through direct, clear, set and invert flavours, control and mask direct only
    // ------------------------------------------------------------------
    assign align_merged = merge_write(align_word, wdata_i, be_i, op);
    assign gap_merged   = merge_write(gap_word, wdata_i, be_i, op);
    assign ctrl_merged  = merge_write(ctrl_word, wdata_i, be_i, WR_DIRECT);
    assign mask_merged  = merge_write(mask_word, wdata_i, be_i, WR_DIRECT);

    // ------------------------------------------------------------------
    // Counter hookup
    // ------------------------------------------------------------------
    // Only the receive path feeds the counter; the transmit end-of-packet
    // strobe goes to the gap timer alone
    assign align_event       = rx_frame_done_i && rx_fcs_bad_i
                             && (rx_len_bits_i != '0);
    assign core.cnt_inc      = align_event;
    // A read with both low byte lanes off leaves the count alone
    assign core.cnt_rd_clear = rd_ok && sel_align && (be_i[1:0] != 2'b00);
    assign core.cnt_wr_en    = wr_ok && sel_align;
    assign core.cnt_wr_val   = align_merged[CNT_W-1:0];

    // ------------------------------------------------------------------
    // Gap timer hookup
    // ------------------------------------------------------------------
    assign core.gap_field   = gap_field_reg;
    assign core.full_duplex = ctrl_reg[CTRL_FD_BIT];
    assign core.frame_end   = tx_frame_end_i;
    assign core.nibble_tick = nibble_tick_i;

    align_err_counter u_counter (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .bus     (core.ctr)
    );

    tx_gap_timer u_gap (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .bus     (core.gap)
    );

    // ------------------------------------------------------------------
    // Interrupt events and sticky status
    // ------------------------------------------------------------------
    // Gap event marks the moment the transmitter may start again
    assign gap_event = core.gap_open && !gap_open_d_reg;
    assign events    = {gap_event, align_event};
    assign stat_clear = (wr_ok && sel_stat) ? wdata_i[EV_W-1:0] : '0;
    // Hardware set wins over a write-one clear in the same cycle
    assign irq_stat_next = (irq_stat_reg & ~stat_clear) | events;
    assign irq_next      = |(irq_stat_next & irq_mask_next);

    // ------------------------------------------------------------------
    // Next values of the software registers
    // ------------------------------------------------------------------
    assign gap_field_next = (wr_ok && sel_gap)  ? gap_merged[GAP_W-1:0]  : gap_field_reg;
    assign ctrl_next      = (wr_ok && sel_ctrl) ? ctrl_merged[0:0]       : ctrl_reg;
    assign irq_mask_next  = (wr_ok && sel_mask) ? mask_merged[EV_W-1:0]  : irq_mask_reg;
    // Read data stand only in the cycle after the strobe
    assign rdata_next     = read_mux;

    // Configuration registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gap_field_reg <= GAP_RESET;
            ctrl_reg      <= CTRL_RESET;
            irq_mask_reg  <= EV_RESET;
        end else if (ce_i) begin
            gap_field_reg <= gap_field_next;
            ctrl_reg      <= ctrl_next;
            irq_mask_reg  <= irq_mask_next;
        end
    end

    // Status, interrupt line and read data; every output but tx_gap_open_o leaves from here
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_stat_reg   <= EV_RESET;
            irq_reg        <= 1'b0;
            rdata_reg      <= '0;
            gap_open_d_reg <= 1'b1;
        end else if (ce_i) begin
            irq_stat_reg   <= irq_stat_next;
            irq_reg        <= irq_next;
            rdata_reg      <= rdata_next;
            gap_open_d_reg <= core.gap_open;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o       = rdata_reg;
    assign irq_o         = irq_reg;
    assign tx_gap_open_o = core.gap_open;

endmodule

//--- verif/mac_ipg_stats_props.sv
// Concurrent checks on the ports of the MAC gap timer and statistics slice
module mac_ipg_stats_props (
    input wire logic                          clk_i,
    input wire logic                          reset_i,
    input wire logic                          ce_i,
    input wire logic [mac_pkg::ADDR_W-1:0]    addr_i,
    input wire logic [mac_pkg::DATA_W-1:0]    wdata_i,
    input wire logic [3:0]                    be_i,
    input wire logic                          wr_i,
    input wire logic                          rd_i,
    input wire logic [mac_pkg::DATA_W-1:0]    rdata_o,
    input wire logic                          rx_frame_done_i,
    input wire logic                          rx_fcs_bad_i,
    input wire logic [mac_pkg::LEN_LSB_W-1:0] rx_len_bits_i,
    input wire logic                          tx_frame_end_i,
    input wire logic                          nibble_tick_i,
    input wire logic                          tx_gap_open_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import mac_pkg::*;
    // --------------------------------------------------------------
    // Reference count, gap field, duplex and nibbles since last end
    // --------------------------------------------------------------
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    logic [15:0] cnt_reg;
    logic [6:0]  fld_reg;
    logic        fd_reg;
    logic [7:0]  nib_reg;
    // Byte-lane accesses never reach the reference, just as they never reach the block
    wire         lo_be   = be_i == BE_WORD || be_i == BE_LO_HALF;
    wire         cnt_sel = addr_i[7:4] == 4'h0 && addr_i[1:0] == 2'h0;
    wire         gap_sel = addr_i[7:4] == 4'h1 && addr_i[1:0] == 2'h0;
    wire         wlo     = ce_i && wr_i && lo_be;
    wire         inc     = ce_i && rx_frame_done_i && rx_fcs_bad_i && rx_len_bits_i != 3'h0;
    wire  [1:0]  op      = addr_i[3:2];
    wire  [15:0] wc      = wdata_i[15:0];
    wire  [15:0] cnt_w   = op == 2'h0 ? wc : op == 2'h1 ? cnt_reg & ~wc :
                           op == 2'h2 ? cnt_reg | wc : cnt_reg ^ wc;
    wire  [6:0]  fld_w   = op == 2'h0 ? wc[6:0] : op == 2'h1 ? fld_reg & ~wc[6:0] :
                           op == 2'h2 ? fld_reg | wc[6:0] : fld_reg ^ wc[6:0];
    wire  [15:0] cnt_b   = (ce_i && rd_i && lo_be && cnt_sel) ? 16'h0 :
                           (wlo && cnt_sel) ? cnt_w : cnt_reg;
    wire  [7:0]  tgt     = {1'b0, fld_reg} + (fd_reg ? FD_GAP_ADD : HD_GAP_ADD);
    // Frozen with ce_i, like the block itself
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= CNT_RESET;
            fld_reg <= GAP_RESET;
            fd_reg  <= 1'b0;
            nib_reg <= 8'h00;
        end else if (ce_i) begin
            cnt_reg <= cnt_b + {15'h0, inc};
            fld_reg <= (wlo && gap_sel) ? fld_w : fld_reg;
            fd_reg  <= (wlo && addr_i == CTRL_OFS) ? wdata_i[CTRL_FD_BIT] : fd_reg;
            nib_reg <= tx_frame_end_i ? 8'h00 :
                       nib_reg + {7'h0, nibble_tick_i && nib_reg != 8'hff};
        end
    end
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    sequence cnt_read_s;
        ce_i && rd_i && lo_be && cnt_sel;
    endsequence
    sequence tx_only_s;
        ce_i && tx_frame_end_i && !inc;
    endsequence
    a_count_read_value: assert property (
        cnt_read_s |=> rdata_o == {16'h0, $past(cnt_reg)}
    ) else $error("count read mismatch");
    a_count_upper_zero: assert property (
        ce_i && rd_i && cnt_sel && be_i == BE_HI_HALF |=> rdata_o[31:16] == 16'h0
    ) else $error("count upper half not zero");
    a_tx_no_count: assert property (
        tx_only_s ##2 cnt_read_s |=> rdata_o[15:0] == $past(cnt_reg)
    ) else $error("transmit frame moved the count");
    a_byte_read_zero: assert property (
        ce_i && rd_i && !(lo_be || be_i == BE_HI_HALF) |=> rdata_o == 32'h0
    ) else $error("byte read returned data");
    a_gap_read_value: assert property (
        ce_i && rd_i && lo_be && gap_sel |=> rdata_o == {25'h0, $past(fld_reg)}
    ) else $error("gap field read mismatch");
    a_gap_closes: assert property (
        ce_i && tx_frame_end_i |=> !tx_gap_open_o
    ) else $error("gap not closed after frame end");
    a_gap_holds_open: assert property (
        tx_gap_open_o && !(ce_i && tx_frame_end_i) |=> tx_gap_open_o
    ) else $error("gap closed without frame end");
    a_gap_length: assert property (
        $rose(tx_gap_open_o) |-> nib_reg == tgt
    ) else $error("gap opened at wrong nibble count");
endmodule

//--- verif/phy_model.sv
// Line-side model: receive frame ends with their qualifiers and a nibble tick
module phy_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       rx_req_i,
    input  wire logic       rx_bad_i,
    input  wire logic [2:0] rx_len_i,
    output logic            rx_frame_done_o,
    output logic            rx_fcs_bad_o,
    output logic [2:0]      rx_len_bits_o,
    output logic            nibble_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Qualifiers are scrambled outside a frame end so nothing leans on stale values;
    // the tick runs faster than the line to keep gap runs short
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_frame_done_o <= 1'b0;
            rx_fcs_bad_o    <= 1'b0;
            rx_len_bits_o   <= 3'h0;
            nibble_tick_o   <= 1'b0;
        end else begin
            rx_frame_done_o <= rx_req_i;
            rx_fcs_bad_o    <= rx_req_i ? rx_bad_i : ~rx_fcs_bad_o;
            rx_len_bits_o   <= rx_req_i ? rx_len_i : ~rx_len_bits_o;
            nibble_tick_o   <= ~nibble_tick_o;
        end
    end
endmodule

//--- verif/tb.sv
// Self-checking bench for the MAC gap timer and alignment statistics slice
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mac_pkg::*;
    logic        clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic        tx_frame_end_i = 1'b0, rq = 1'b0, rbad = 1'b0;
    logic [2:0]  rlen = 3'h0;
    logic [7:0]  addr_i = 8'h00;
    logic [3:0]  be_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic        irq_o, tx_gap_open_o, rx_frame_done_i, rx_fcs_bad_i, nibble_tick_i;
    logic [2:0]  rx_len_bits_i;
    int          err_count = 0, checked = 0;
    mac_ipg_stats dut (.*);
    phy_model phy (.clk_i, .reset_i, .rx_req_i(rq), .rx_bad_i(rbad), .rx_len_i(rlen),
                   .rx_frame_done_o(rx_frame_done_i), .rx_fcs_bad_o(rx_fcs_bad_i),
                   .rx_len_bits_o(rx_len_bits_i), .nibble_tick_o(nibble_tick_i));
    // --------------------------------------------------------------
    // Clock, bus and comparison helpers
    // --------------------------------------------------------------
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One strobe cycle; returns just after the edge where read data lands
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        be_i    <= b;
        wr_i    <= w;
        rd_i    <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] e);
        bus(1'b0, a, 32'h0, b);
        chk(rdata_o, e);
    endtask
    // A transmit end, or a receive end through the line model
    task automatic ev(input logic tx, input logic bad, input logic [2:0] len);
        @(posedge clk_i);
        rq             <= !tx;
        tx_frame_end_i <= tx;
        rbad           <= bad;
        rlen           <= len;
        @(posedge clk_i);
        rq             <= 1'b0;
        tx_frame_end_i <= 1'b0;
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] ofs [6] = '{ALIGN_OFS, GAP_OFS, CTRL_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS, 8'h30};
        for (int i = 0; i < 6; i++) rc(ofs[i], BE_WORD, i == 1 ? {25'h0, GAP_RESET} : 32'h0);
        chk({31'h0, tx_gap_open_o}, 32'h1);
    endtask
    // Whole-byte, good-FCS and transmitted frames must not count
    task automatic t_count;
        for (int l = 0; l < 8; l++) ev(1'b0, 1'b1, 3'(l));
        ev(1'b0, 1'b0, 3'h5);
        ev(1'b1, 1'b1, 3'h5);
        rc(ALIGN_OFS, BE_WORD, 32'h7);
        rc(ALIGN_OFS + CLR_OFS, BE_LO_HALF, 32'h0);
        ev(1'b0, 1'b1, 3'h1);
        rc(ALIGN_OFS, 4'h1, 32'h0);
        bus(1'b0, ALIGN_OFS, 32'h0, BE_HI_HALF);
        chk(rdata_o & 32'hffff_0000, 32'h0);
        rc(ALIGN_OFS, BE_WORD, 32'h1);
    endtask
    task automatic t_alias;
        bus(1'b1, ALIGN_OFS, 32'hffff_fffe, BE_WORD);
        rc(ALIGN_OFS + INV_OFS, BE_WORD, 32'h0000_fffe);
        bus(1'b1, ALIGN_OFS + SET_OFS, 32'h0000_f0f0, BE_LO_HALF);
        bus(1'b1, ALIGN_OFS + CLR_OFS, 32'h0000_00f0, BE_WORD);
        bus(1'b1, ALIGN_OFS + INV_OFS, 32'h0000_0f0f, BE_WORD);
        bus(1'b1, ALIGN_OFS, 32'h0000_0000, 4'h2);
        rc(ALIGN_OFS, BE_WORD, 32'h0000_ff0f);
        bus(1'b1, ALIGN_OFS + SET_OFS, 32'h0000_ffff, BE_WORD);
        ev(1'b0, 1'b1, 3'h7);
        rc(ALIGN_OFS, BE_WORD, 32'h0);
    endtask
    // Counts the nibble ticks the block waits after a frame end
    task automatic t_gap(input logic fd, input logic [6:0] f);
        int   n;
        logic t;
        n = 0;
        bus(1'b1, CTRL_OFS, {31'h0, fd}, BE_WORD);
        bus(1'b1, GAP_OFS, {25'h0, f}, BE_LO_HALF);
        bus(1'b1, GAP_OFS, 32'h0, 4'h1);
        bus(1'b1, GAP_OFS, 32'hffff_ffff, BE_HI_HALF);
        rc(GAP_OFS, BE_WORD, {25'h0, f});
        ev(1'b1, 1'b0, 3'h0);
        #1;
        chk({31'h0, tx_gap_open_o}, 32'h0);
        for (int i = 0; i < 400 && !tx_gap_open_o; i++) begin
            t = nibble_tick_i;
            @(posedge clk_i);
            #1;
            n += int'(t);
        end
        chk(32'(n), {25'h0, f} + {24'h0, fd ? FD_GAP_ADD : HD_GAP_ADD});
    endtask
    task automatic t_irq;
        bus(1'b1, IRQ_STAT_OFS, 32'h3, BE_WORD);
        bus(1'b1, IRQ_MASK_OFS, 32'h1, BE_WORD);
        ev(1'b0, 1'b1, 3'h5);
        @(posedge clk_i);
        #1;
        chk({31'h0, irq_o}, 32'h1);
        bus(1'b1, IRQ_STAT_OFS, 32'h1, BE_WORD);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, IRQ_MASK_OFS, 32'h0, BE_WORD);
        ev(1'b0, 1'b1, 3'h2);
        rc(IRQ_STAT_OFS, BE_WORD, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
    endtask
    task automatic wrap_up;
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence; the gap table covers both duplex modes and field extremes
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_count;
        t_alias;
        t_gap(1'b1, 7'h15);
        t_gap(1'b0, 7'h12);
        t_gap(1'b1, 7'h00);
        t_gap(1'b0, 7'h7f);
        t_irq;
        wrap_up;
    end
    // Hang guard, well beyond the few hundred cycles the run needs
    initial begin
        repeat (10000) @(posedge clk_i);
        err_count++;
        wrap_up;
    end
endmodule
bind mac_ipg_stats mac_ipg_stats_props props (.*);
